// file: hdl/pllc_ctrl.sv
// Overview of operation
// - direction 0 delays, 1 advances output
// - select 000 picks first secondary output
// - codes 001..101 pick secondary 2..5, primary
// - step shifts fine over eight times divide
// - step request taken on falling edge
// - delay glitch free, advance may glitch
// - load shifts coarse minus divide, from unshifted
// - coarse and divide both one: no shift
// - per-output enable, disabled held low, glitchless
// - re-enabled output restarts on primary fall
// - no enable for feedback or absent outputs
// - standby stops counters, all outputs low
// - restart and relock within ten milliseconds
// - lock indication, sticky or drops on loss
`timescale 1ns/1ps
`include "pllc_params.svh"

module pllc_ctrl
    import pllc_pkg::*;
#(
    parameter int LOCK_CYCLES = `PLLC_LOCK_CYCLES,
    parameter bit STICKY_LOCK = 1'b0,
    parameter logic [5:0] GATE_AVAIL = 6'h3f
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // static divider settings, index = select code
    input wire pllc_out_cfg_type out_cfg_i [`PLLC_NUM_OUT],
    // dynamic phase shift
    input wire logic [2:0] shift_output_select_i,
    input wire logic shift_direction_i,
    input wire logic vco_step_strobe_i,
    input wire logic divider_phase_load_strobe_i,
    // output gates
    input wire logic primary_out_gate_i,
    input wire logic secondary_out_gate_1_i,
    input wire logic secondary_out_gate_2_i,
    input wire logic secondary_out_gate_3_i,
    input wire logic secondary_out_gate_4_i,
    input wire logic secondary_out_gate_5_i,
    // standby and reference status
    input wire logic standby_request_i,
    input wire logic ref_clock_valid_i,
    // clocks and lock
    output logic primary_out_clock_o,
    output logic secondary_out_clock_1_o,
    output logic secondary_out_clock_2_o,
    output logic secondary_out_clock_3_o,
    output logic secondary_out_clock_4_o,
    output logic secondary_out_clock_5_o,
    output logic lock_o
);

    function automatic logic [5:0] sel_decode(input logic [2:0] sel);
        logic [5:0] hot;
        hot = 6'h00;
        if (sel <= `PLLC_SEL_PRIMARY)
        begin
            hot = 6'h01 << (sel - `PLLC_SEL_SEC1);
        end
        return hot;
    endfunction

    // two-stage synchronisers for all pin inputs except reset and the divider settings
    localparam int NSYNC = 14;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    wire [NSYNC-1:0] pins = {primary_out_gate_i, secondary_out_gate_5_i,
        secondary_out_gate_4_i, secondary_out_gate_3_i,
        secondary_out_gate_2_i, secondary_out_gate_1_i,
        shift_output_select_i, shift_direction_i, vco_step_strobe_i,
        divider_phase_load_strobe_i, standby_request_i, ref_clock_valid_i};

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= pins;
            sync_b <= sync_a;
        end
    end

    pllc_shift_req_type req;
    wire [5:0] gate_s = sync_b[13:8];
    wire step_s = sync_b[3];
    wire load_s = sync_b[2];
    wire stby_s = sync_b[1];
    wire ref_ok_s = sync_b[0];
    assign req.shift_output_select = sync_b[7:5];
    assign req.shift_direction = sync_b[4];

    // strobe edge detection on the synchronised copies
    logic step_q;
    logic load_q;
    wire step_fall = step_q & ~step_s;
    wire load_fall = load_q & ~load_s;
    // caller keeps select steady across strobes, so no lock is taken here
    wire [5:0] target_hot = sel_decode(req.shift_output_select);

    // standby and lock sequencing
    pllc_state_type state;
    pllc_state_type next_state;
    logic [`PLLC_LOCK_W-1:0] lock_cnt;
    logic [`PLLC_LOCK_W-1:0] next_lock_cnt;
    logic next_lock;
    wire lock_done = lock_cnt >= `PLLC_LOCK_W'(LOCK_CYCLES - 1);

    always_comb
    begin
        next_state = state;
        next_lock_cnt = lock_cnt;
        next_lock = lock_o;
        case (state)
            PLLC_ST_STANDBY:
            begin
                next_lock = 1'b0;
                next_lock_cnt = '0;
                if (!stby_s)
                begin
                    next_state = PLLC_ST_RELOCK;
                end
            end
            PLLC_ST_RELOCK:
            begin
                next_lock = 1'b0;
                if (ref_ok_s)
                begin
                    next_lock_cnt = lock_cnt + 1'b1;
                end
                if (ref_ok_s && lock_done)
                begin
                    next_state = PLLC_ST_LOCKED;
                    next_lock = 1'b1;
                end
            end
            PLLC_ST_LOCKED:
            begin
                // sticky lock ignores a lost reference
                if (!ref_ok_s && !STICKY_LOCK)
                begin
                    next_state = PLLC_ST_RELOCK;
                    next_lock = 1'b0;
                    next_lock_cnt = '0;
                end
            end
            default:
            begin
                next_state = PLLC_ST_RELOCK;
                next_lock = 1'b0;
            end
        endcase
        if (stby_s)
        begin
            next_state = PLLC_ST_STANDBY;
            next_lock = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state <= PLLC_ST_RELOCK;
            lock_cnt <= '0;
            lock_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            lock_cnt <= next_lock_cnt;
            lock_o <= next_lock;
        end
    end

    wire run = (state != PLLC_ST_STANDBY) && !stby_s;

    // per-output divider, phase and gate
    logic [5:0] raw;
    logic [5:0] oclk;
    logic [5:0] gate;
    logic prim_ref;
    wire prim_fall = prim_ref & ~raw[`PLLC_PRIMARY_IDX];

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            prim_ref <= 1'b0;
            step_q <= 1'b0;
            load_q <= 1'b0;
        end
        else
        begin
            prim_ref <= raw[`PLLC_PRIMARY_IDX];
            step_q <= step_s;
            load_q <= load_s;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `PLLC_NUM_OUT; i++)
        begin : g_out
            logic [`PLLC_CNT_W-1:0] cnt;
            logic signed [`PLLC_OFF_W-1:0] pend;
            logic signed [`PLLC_OFF_W-1:0] offs;
            wire pllc_out_cfg_type cfg = out_cfg_i[i];
            // period is eight fine units per divide step
            wire [`PLLC_CNT_W-1:0] period = `PLLC_CNT_W'(
                {cfg.output_divide_ratio, 3'h0});
            wire [`PLLC_CNT_W-1:0] half = `PLLC_CNT_W'(
                {cfg.output_divide_ratio, 2'h0});
            wire [`PLLC_CNT_W:0] inc = (pend < 0) ? 11'h002 : 11'h001;
            wire [`PLLC_CNT_W:0] sum = {1'b0, cnt} + inc;
            wire [`PLLC_CNT_W-1:0] wrapped = (sum >= {1'b0, period})
                ? `PLLC_CNT_W'(sum - {1'b0, period})
                : sum[`PLLC_CNT_W-1:0];
            wire signed [`PLLC_OFF_W-1:0] fine_amt =
                `PLLC_OFF_W'({1'b0, cfg.fine_phase_setting});
            wire signed [`PLLC_OFF_W-1:0] step_delta =
                (req.shift_direction == `PLLC_DIR_DELAY)
                ? fine_amt : -fine_amt;
            // coarse minus divide, in divide steps of eight fine units, from unshifted
            wire signed [`PLLC_OFF_W-1:0] load_tgt_raw =
                (`PLLC_OFF_W'(cfg.coarse_phase_setting)
                - `PLLC_OFF_W'(cfg.output_divide_ratio))
                <<< `PLLC_LOAD_UNIT_SHIFT;
            wire signed [`PLLC_OFF_W-1:0] load_tgt =
                (req.shift_direction == `PLLC_DIR_DELAY)
                ? load_tgt_raw : -load_tgt_raw;
            wire step_hit = step_fall & target_hot[i];
            wire load_hit = load_fall & target_hot[i];
            wire signed [`PLLC_OFF_W-1:0] req_delta = load_hit
                ? (load_tgt - offs) : (step_hit ? step_delta : '0);
            // delay stalls the counter, advance skips counts
            wire signed [`PLLC_OFF_W-1:0] drain = (pend > 0)
                ? -`PLLC_OFF_W'sd1 : ((pend < 0) ? `PLLC_OFF_W'sd1 : '0);
            wire avail = GATE_AVAIL[i];
            wire en = avail ? gate_s[i] : 1'b1;
            // disable only while low, enable only at primary fall
            wire next_gate = en ? (gate[i] | prim_fall)
                : (gate[i] & raw[i]);

            assign raw[i] = run && (cnt < half);

            always_ff @(posedge clk_i)
            begin
                if (!resetn_i)
                begin
                    cnt <= '0;
                    pend <= '0;
                    offs <= '0;
                    gate[i] <= 1'b0;
                    oclk[i] <= 1'b0;
                end
                else if (!run)
                begin
                    cnt <= '0;
                    pend <= '0;
                    // restart is unshifted, so the offset must go too
                    offs <= '0;
                    gate[i] <= en;
                    oclk[i] <= 1'b0;
                end
                else
                begin
                    cnt <= (pend > 0) ? cnt : wrapped;
                    pend <= pend + drain + req_delta;
                    offs <= offs + req_delta;
                    gate[i] <= next_gate;
                    oclk[i] <= raw[i] & next_gate;
                end
            end
        end
    endgenerate

    assign secondary_out_clock_1_o = oclk[0];
    assign secondary_out_clock_2_o = oclk[1];
    assign secondary_out_clock_3_o = oclk[2];
    assign secondary_out_clock_4_o = oclk[3];
    assign secondary_out_clock_5_o = oclk[4];
    assign primary_out_clock_o = oclk[`PLLC_PRIMARY_IDX];

endmodule

// file: hdl/pllc_params.svh
`ifndef PLLC_PARAMS_SVH
`define PLLC_PARAMS_SVH

`define PLLC_NUM_OUT 6
`define PLLC_PRIMARY_IDX 5
`define PLLC_SEL_SEC1 3'h0
`define PLLC_SEL_PRIMARY 3'h5
`define PLLC_DIR_DELAY 1'b0
`define PLLC_FINE_PER_DIV 3
`define PLLC_HALF_SHIFT 2
`define PLLC_LOAD_UNIT_SHIFT 3
`define PLLC_CNT_W 10
`define PLLC_OFF_W 12
`define PLLC_LOCK_W 18
`define PLLC_CLK_HZ 20000000
`define PLLC_MS_PER_S 1000
`define PLLC_LOCK_TIME_MS 10
`define PLLC_LOCK_CYCLES (`PLLC_LOCK_TIME_MS * `PLLC_CLK_HZ / `PLLC_MS_PER_S)

`endif

// file: hdl/pllc_pkg.sv
package pllc_pkg;

    // static per-output divider settings
    typedef struct packed {
        logic [6:0] output_divide_ratio;
        logic [6:0] coarse_phase_setting;
        logic [2:0] fine_phase_setting;
    } pllc_out_cfg_type;

    typedef struct packed {
        logic [2:0] shift_output_select;
        logic shift_direction;
    } pllc_shift_req_type;

    typedef enum logic [1:0] {
        PLLC_ST_STANDBY,
        PLLC_ST_RELOCK,
        PLLC_ST_LOCKED
    } pllc_state_type;

endpackage

// file: test/pllc_ctrl_props.sv
`timescale 1ns/1ps
module pllc_ctrl_props
#(
    parameter int LOCK_CYCLES = 20
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // control inputs
    input wire logic standby_request_i,
    input wire logic ref_clock_valid_i,
    input wire logic primary_out_gate_i,
    input wire logic secondary_out_gate_1_i,
    // clocks and lock
    input wire logic primary_out_clock_o,
    input wire logic secondary_out_clock_1_o,
    input wire logic secondary_out_clock_2_o,
    input wire logic secondary_out_clock_3_o,
    input wire logic secondary_out_clock_4_o,
    input wire logic secondary_out_clock_5_o,
    input wire logic lock_o
);
    logic [5:0] clks;
    logic run;
    int quiet;
    int low_p;
    int low_1;
    assign clks = {primary_out_clock_o, secondary_out_clock_5_o,
        secondary_out_clock_4_o, secondary_out_clock_3_o,
        secondary_out_clock_2_o, secondary_out_clock_1_o};
    assign run = resetn_i && ref_clock_valid_i && !standby_request_i;
    // counters replace long repetitions
    always_ff @(posedge clk_i)
    begin
        quiet <= run ? quiet + 1 : 0;
        low_p <= primary_out_gate_i ? 0 : low_p + 1;
        low_1 <= secondary_out_gate_1_i ? 0 : low_1 + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_reset_clears: assert property (
        $rose(resetn_i) |-> clks == 6'h00 && !lock_o)
        else $error("outputs not clear after reset");
    a_standby_clocks_low: assert property (
        standby_request_i [*5] |-> clks == 6'h00)
        else $error("clock running in standby");
    a_standby_lock_low: assert property (
        standby_request_i [*5] |-> !lock_o)
        else $error("lock high in standby");
    a_gate1_held_low: assert property (
        low_1 > 16 |-> !secondary_out_clock_1_o)
        else $error("gated output not low");
    a_primary_held_low: assert property (
        low_p > 16 |-> !primary_out_clock_o)
        else $error("gated primary not low");
    a_lock_not_early: assert property (
        $rose(lock_o) |-> quiet >= LOCK_CYCLES - 1)
        else $error("lock came too early");
    a_lock_not_late: assert property (
        quiet > LOCK_CYCLES + 6 |-> lock_o)
        else $error("lock came too late");
    a_lock_drops: assert property (
        !ref_clock_valid_i [*6] |-> !lock_o)
        else $error("lock held with invalid reference");
    cover property ($rose(lock_o));
    cover property (low_1 > 16);
    cover property (standby_request_i [*5]);
endmodule

bind pllc_ctrl pllc_ctrl_props #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .standby_request_i(standby_request_i),
    .ref_clock_valid_i(ref_clock_valid_i),
    .primary_out_gate_i(primary_out_gate_i),
    .secondary_out_gate_1_i(secondary_out_gate_1_i),
    .primary_out_clock_o(primary_out_clock_o),
    .secondary_out_clock_1_o(secondary_out_clock_1_o),
    .secondary_out_clock_2_o(secondary_out_clock_2_o),
    .secondary_out_clock_3_o(secondary_out_clock_3_o),
    .secondary_out_clock_4_o(secondary_out_clock_4_o),
    .secondary_out_clock_5_o(secondary_out_clock_5_o),
    .lock_o(lock_o));

// file: test/pllc_fabric.sv
`timescale 1ns/1ps
module pllc_fabric
    import pllc_pkg::*;
(
    // clock and settings
    input wire logic clk_i,
    input wire pllc_out_cfg_type cfg_i [6],
    // shift control
    output logic [2:0] shift_output_select_o = 3'h0,
    output logic shift_direction_o = 1'b0,
    output logic vco_step_strobe_o = 1'b0,
    output logic divider_phase_load_strobe_o = 1'b0
);
    // one shift at a time, whole wait inside the call
    task automatic shift(input logic [2:0] sel, input logic dir,
        input logic load);
        int k;
        int gap;
        k = (sel > 3'h5) ? 0 : int'(sel);
        gap = (5 * (cfg_i[k].output_divide_ratio + 1) / 2 + 2 +
            cfg_i[k].coarse_phase_setting) *
            8 * cfg_i[k].output_divide_ratio;
        @(negedge clk_i);
        shift_output_select_o <= sel;
        shift_direction_o <= dir;
        repeat (4) @(negedge clk_i);
        if (load)
            divider_phase_load_strobe_o <= 1'b1;
        else
            vco_step_strobe_o <= 1'b1;
        repeat (4) @(negedge clk_i);
        vco_step_strobe_o <= 1'b0;
        divider_phase_load_strobe_o <= 1'b0;
        repeat (gap) @(negedge clk_i);
    endtask
endmodule

// file: test/pllc_ctrl_test.sv
`timescale 1ns/1ps
module pllc_ctrl_test
    import pllc_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic stby = 1'b0;
    logic refv = 1'b1;
    logic [5:0] gate = 6'h3f;
    logic [5:0] prev = 6'h00;
    wire logic [5:0] clks;
    wire logic [2:0] sel;
    wire logic dir;
    wire logic step;
    wire logic load;
    wire logic lock;
    pllc_out_cfg_type cfg [6];
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    int rise [6] = '{default: 0};
    int p0 [6];
    int t0;
    int exp_dp;
    // rows: {select, direction, load} and phase change of the target
    logic [4:0] r_in [11] = '{5'h00, 5'h06, 5'h08, 5'h0c, 5'h12, 5'h14,
        5'h01, 5'h13, 5'h15, 5'h18, 5'h1f};
    int r_dp [11] = '{1, 14, 3, 4, 11, 2, 7, 13, 6, 0, 0};
    always #25 clk_i = ~clk_i;
    pllc_ctrl #(.LOCK_CYCLES(20)) dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .out_cfg_i(cfg),
        .shift_output_select_i(sel), .shift_direction_i(dir),
        .vco_step_strobe_i(step), .divider_phase_load_strobe_i(load),
        .primary_out_gate_i(gate[5]), .secondary_out_gate_1_i(gate[0]),
        .secondary_out_gate_2_i(gate[1]), .secondary_out_gate_3_i(gate[2]),
        .secondary_out_gate_4_i(gate[3]), .secondary_out_gate_5_i(gate[4]),
        .standby_request_i(stby), .ref_clock_valid_i(refv),
        .primary_out_clock_o(clks[5]), .secondary_out_clock_1_o(clks[0]),
        .secondary_out_clock_2_o(clks[1]), .secondary_out_clock_3_o(clks[2]),
        .secondary_out_clock_4_o(clks[3]), .secondary_out_clock_5_o(clks[4]),
        .lock_o(lock));
    pllc_fabric fab_u (.clk_i(clk_i), .cfg_i(cfg),
        .shift_output_select_o(sel), .shift_direction_o(dir),
        .vco_step_strobe_o(step), .divider_phase_load_strobe_o(load));
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // phase of output i within its own period
    function automatic int md(input int x, input int i);
        int p;
        p = 8 * cfg[i].output_divide_ratio;
        return ((x % p) + p) % p;
    endfunction
    always @(negedge clk_i)
    begin
        cyc++;
        for (int i = 0; i < 6; i++)
            if (clks[i] === 1'b1 && prev[i] === 1'b0)
                rise[i] = cyc;
        prev = clks;
        if (cyc > 30000)
        begin
            failures++;
            close_out();
        end
    end
    initial
    begin
        for (int i = 0; i < 5; i++)
            cfg[i] = '{7'h02, 7'h03, 3'(i + 1)};
        cfg[5] = '{7'h01, 7'h01, 3'h2};
        repeat (12) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (30) @(negedge clk_i);
        check(lock, 1'b1);
        for (int r = 0; r < 11; r++)
        begin
            for (int i = 0; i < 6; i++)
                p0[i] = rise[i];
            fab_u.shift(r_in[r][4:2], r_in[r][1], r_in[r][0]);
            for (int i = 0; i < 6; i++)
            begin
                exp_dp = (i == r_in[r][4:2]) ? r_dp[r] : 0;
                check(md(rise[i] - p0[i], i), exp_dp);
            end
            $display("row %0d done", r);
        end
        gate = 6'h1e;
        repeat (20) @(negedge clk_i);
        p0[0] = rise[0];
        p0[5] = rise[5];
        repeat (40) @(negedge clk_i);
        check({rise[0] == p0[0], rise[5] == p0[5], clks[0], clks[5]},
            4'hc);
        gate = 6'h3f;
        repeat (40) @(negedge clk_i);
        check(rise[0] > p0[0] && rise[5] > p0[5], 1'b1);
        $display("gating done");
        stby = 1'b1;
        repeat (10) @(negedge clk_i);
        check({clks, lock}, 7'h00);
        repeat (20000) @(negedge clk_i);
        stby = 1'b0;
        t0 = cyc;
        repeat (5) @(negedge clk_i);
        check(lock, 1'b0);
        repeat (25) @(negedge clk_i);
        check({lock, rise[5] > t0}, 2'h3);
        $display("standby done");
        refv = 1'b0;
        repeat (8) @(negedge clk_i);
        check(lock, 1'b0);
        refv = 1'b1;
        repeat (30) @(negedge clk_i);
        check(lock, 1'b1);
        $display("lock loss done");
        close_out();
    end
endmodule
